// ---- rtl/rscl_pkg.sv ----
package rscl_pkg;
	// Register port widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// Register addresses
	localparam logic [3:0] ADDR_CONFIG = 4'h0;
	localparam logic [3:0] ADDR_GPIO_DIR = 4'h1;
	localparam logic [3:0] ADDR_GPIO_OUT = 4'h2;
	localparam logic [3:0] ADDR_PIN_LEVEL = 4'h3;
	localparam logic [3:0] ADDR_IRQ_SEL = 4'h4;
	localparam logic [3:0] ADDR_IRQ_POL = 4'h5;
	localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
	localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h7;
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h8;
	// Positions in the synchronised pin vector, straps in the low byte
	localparam int PIN_BYTE_ORDER = 0;
	localparam int PIN_HOST_WIDTH = 1;
	localparam int PIN_PCI_SEL = 2;
	localparam int PIN_AUTOINIT = 3;
	localparam int PIN_BOOT_LO = 4;
	localparam int PIN_ECLK_LO = 6;
	localparam int PIN_NMI = 8;
	localparam int PIN_GPIO_LO = 9;
	localparam int NGPIO = 4;
	localparam int NPINS = 13;
	localparam int CFG_W = 8;
	// Interrupt status layout: pins 4..7 in bits 3:0, nmi in bit 4
	localparam int STAT_W = 5;
	localparam int STAT_NMI = 4;
	// Irq select bits sit at 7:4 of the select register
	localparam int IRQ_SEL_LO = 4;
	// Strap defaults shown until the capture is done: little-endian,
	// 16-bit host port, no PCI, no auto-init, ROM boot, external clock
	localparam logic [7:0] CFG_RESET = 8'h31;
	// Boot source codes
	localparam logic [1:0] BOOT_NONE = 2'h0;
	localparam logic [1:0] BOOT_HOST = 2'h1;
	localparam logic [1:0] BOOT_RSVD = 2'h2;
	localparam logic [1:0] BOOT_ROM = 2'h3;
	// External memory clock select codes
	localparam logic [1:0] ECLK_EXT = 2'h0;
	localparam logic [1:0] ECLK_DIV4 = 2'h1;
	localparam logic [1:0] ECLK_DIV6 = 2'h2;
	localparam logic [1:0] ECLK_RSVD = 2'h3;
	// Divider terminal counts (ratio minus one)
	localparam logic [2:0] DIV4_LAST = 3'h3;
	localparam logic [2:0] DIV6_LAST = 3'h5;
	// Cycles from reset release until the pin filter holds real levels
	localparam logic [2:0] SETTLE_LAST = 3'h3;
	// Capture sequencer, one-hot
	typedef enum logic [2:0] {
		ST_SETTLE = 3'b001,
		ST_CAPTURE = 3'b010,
		ST_HELD = 3'b100
	} rscl_state_e;
endpackage

// ---- rtl/rscl_top.sv ----
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Byte order strap 0 selects big-endian, 1 little-endian, little is default.
// - Host port width is taken from the host data bit 5 strap at reset.
// - Width strap 0: host port 16 bits, upper data lines 31:16 stay off.
// - Width strap 1: host port 32 bits, all host data lines used.
// - PCI select picks PCI, or host port plus GPIO pins 15 to 9.
// - Auto-init strap 0 disables EEPROM PCI auto-init, 1 enables it.
// - Boot strap: 00 none, 01 host port, 10 reserved, 11 8-bit ROM.
// - Memory clock: 00 external input, 01 core/4, 10 core/6, 11 reserved.
// - Nonmaskable interrupt fires on a rising edge of its input.
// - After reset GPIO pins 7 and 6 are inputs, drivers off.
// - Each shared pin is either tristatable GPIO or input-only interrupt.
// - Interrupt pins are edge-triggered; enable and polarity bits per pin.
module rscl_top (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// Configuration straps
	input wire logic i_byte_order_strap,
	input wire logic i_host_width_strap,
	input wire logic i_pci_select,
	input wire logic i_eeprom_autoinit_strap,
	input wire logic [1:0] i_boot_strap,
	input wire logic [1:0] i_ext_mem_clock_select,
	// Interrupt and shared GPIO pins, index 0 is pin 4
	input wire logic i_nmi,
	input wire logic [3:0] i_gpio_irq_pin,
	output logic [3:0] o_gpio_irq_pin,
	output logic [3:0] o_gpio_irq_pin_oe,
	// Register port
	input wire logic [3:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Decoded configuration
	output logic o_config_valid,
	output logic o_big_endian,
	output logic o_host_port_wide,
	output logic o_host_upper_lanes_en,
	output logic o_pci_enable,
	output logic o_host_port_enable,
	output logic o_gpio_hi_enable,
	output logic o_pci_autoinit,
	output logic o_boot_none,
	output logic o_boot_host,
	output logic o_boot_rom,
	output logic o_boot_reserved,
	output logic o_emclk_use_ext,
	output logic o_emclk_reserved,
	output logic o_emclk_tick,
	// Interrupts
	output logic o_nmi_pulse,
	output logic o_irq
);
	localparam int NP = rscl_pkg::NPINS;
	localparam int NG = rscl_pkg::NGPIO;
	localparam int GL = rscl_pkg::PIN_GPIO_LO;

	logic [NP-1:0] pins_w;
	logic [NP-1:0] s1_r, s2_r, s3_r, filt_r, prev_r;
	logic [NP-1:0] s1_nxt, s2_nxt, s3_nxt, filt_nxt, prev_nxt;
	rscl_pkg::rscl_state_e st_r, st_nxt;
	logic [2:0] cnt_r, cnt_nxt;
	logic [7:0] cfg_r, cfg_nxt;
	logic [2:0] div_r, div_nxt;
	logic tick_r, tick_nxt;
	logic [NG-1:0] dir_r, dir_nxt, out_r, out_nxt;
	logic [NG-1:0] sel_r, sel_nxt, pol_r, pol_nxt;
	logic [4:0] status_r, status_nxt, enable_r, enable_nxt;
	logic nmi_r, nmi_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic held_w;
	logic [NP-1:0] rise_w, fall_w;
	logic [NG-1:0] ext_ev_w;
	logic nmi_ev_w;
	logic [4:0] clear_w;
	logic [1:0] boot_w, eclk_w;
	logic div_mode_w;
	logic [2:0] div_last_w;

	// Gather the straps, the nmi input and the shared pins into one vector for the filter
	assign pins_w = {i_gpio_irq_pin, i_nmi, i_ext_mem_clock_select,
		i_boot_strap, i_eeprom_autoinit_strap, i_pci_select,
		i_host_width_strap, i_byte_order_strap};

	// Three-stage synchroniser; a level counts once stages two and three agree
	always_comb begin
		s1_nxt = pins_w;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		filt_nxt = (filt_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
		prev_nxt = filt_r;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			filt_r <= '0;
			prev_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			filt_r <= filt_nxt;
			prev_r <= prev_nxt;
		end
	end

	// Edges of the filtered levels; ignored until capture completes so the
	// filter filling up after reset is never mistaken for an event
	assign held_w = (st_r == rscl_pkg::ST_HELD);
	assign rise_w = filt_r & ~prev_r;
	assign fall_w = ~filt_r & prev_r;

	// Strap capture: wait for the filter to fill, latch once, then hold
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		cfg_nxt = cfg_r;
		case (st_r)
			rscl_pkg::ST_SETTLE: begin
				if (cnt_r == rscl_pkg::SETTLE_LAST) begin
					st_nxt = rscl_pkg::ST_CAPTURE;
				end else begin
					cnt_nxt = cnt_r + 3'h1;
				end
			end
			rscl_pkg::ST_CAPTURE: begin
				cfg_nxt = filt_r[rscl_pkg::CFG_W-1:0];
				st_nxt = rscl_pkg::ST_HELD;
			end
			rscl_pkg::ST_HELD: begin
				cfg_nxt = cfg_r;
			end
			default: begin
				st_nxt = rscl_pkg::ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			st_r <= rscl_pkg::ST_SETTLE;
			cnt_r <= 3'h0;
			cfg_r <= rscl_pkg::CFG_RESET;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			cfg_r <= cfg_nxt;
		end
	end

	// Decode of the held straps
	assign boot_w = cfg_r[rscl_pkg::PIN_BOOT_LO +: 2];
	assign eclk_w = cfg_r[rscl_pkg::PIN_ECLK_LO +: 2];
	assign o_config_valid = held_w;
	assign o_big_endian = ~cfg_r[rscl_pkg::PIN_BYTE_ORDER];
	assign o_host_port_wide = cfg_r[rscl_pkg::PIN_HOST_WIDTH];
	// Upper data lanes stay released in the narrow mode
	assign o_host_upper_lanes_en = cfg_r[rscl_pkg::PIN_HOST_WIDTH];
	assign o_pci_enable = cfg_r[rscl_pkg::PIN_PCI_SEL];
	assign o_host_port_enable = ~cfg_r[rscl_pkg::PIN_PCI_SEL];
	assign o_gpio_hi_enable = ~cfg_r[rscl_pkg::PIN_PCI_SEL];
	// Passed as strapped; the board keeps it low without PCI
	assign o_pci_autoinit = cfg_r[rscl_pkg::PIN_AUTOINIT];
	assign o_boot_none = (boot_w == rscl_pkg::BOOT_NONE);
	assign o_boot_host = (boot_w == rscl_pkg::BOOT_HOST);
	assign o_boot_rom = (boot_w == rscl_pkg::BOOT_ROM);
	// Flags a board that strapped the reserved boot code 10
	assign o_boot_reserved = (boot_w == rscl_pkg::BOOT_RSVD);
	assign o_emclk_use_ext = (eclk_w == rscl_pkg::ECLK_EXT);
	assign o_emclk_reserved = (eclk_w == rscl_pkg::ECLK_RSVD);

	// Core clock divider for the memory clock, an enable pulse per period
	assign div_mode_w = held_w && (eclk_w == rscl_pkg::ECLK_DIV4 ||
		eclk_w == rscl_pkg::ECLK_DIV6);
	assign div_last_w = (eclk_w == rscl_pkg::ECLK_DIV4) ?
		rscl_pkg::DIV4_LAST : rscl_pkg::DIV6_LAST;

	always_comb begin
		div_nxt = 3'h0;
		tick_nxt = 1'b0;
		if (div_mode_w) begin
			if (div_r == div_last_w) begin
				tick_nxt = 1'b1;
			end else begin
				div_nxt = div_r + 3'h1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			div_r <= 3'h0;
			tick_r <= 1'b0;
		end else begin
			div_r <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_emclk_tick = tick_r;

	// Interrupt events; polarity 0 takes rising edges, 1 falling edges
	assign nmi_ev_w = held_w & rise_w[rscl_pkg::PIN_NMI];
	assign ext_ev_w = {NG{held_w}} & sel_r &
		((~pol_r & rise_w[GL +: NG]) | (pol_r & fall_w[GL +: NG]));
	assign clear_w = (i_wr && i_addr == rscl_pkg::ADDR_IRQ_CLEAR) ?
		i_wdata[4:0] : 5'h00;

	// Register writes and sticky status; a set in the clear cycle wins
	always_comb begin
		dir_nxt = dir_r;
		out_nxt = out_r;
		sel_nxt = sel_r;
		pol_nxt = pol_r;
		enable_nxt = enable_r;
		if (i_wr) begin
			case (i_addr)
				rscl_pkg::ADDR_GPIO_DIR: dir_nxt = i_wdata[NG-1:0];
				rscl_pkg::ADDR_GPIO_OUT: out_nxt = i_wdata[NG-1:0];
				rscl_pkg::ADDR_IRQ_SEL: begin
					sel_nxt = i_wdata[rscl_pkg::IRQ_SEL_LO +: NG];
				end
				rscl_pkg::ADDR_IRQ_POL: pol_nxt = i_wdata[NG-1:0];
				rscl_pkg::ADDR_IRQ_ENABLE: enable_nxt = i_wdata[4:0];
				default: begin
					dir_nxt = dir_r;
				end
			endcase
		end
		status_nxt = (status_r & ~clear_w) | {nmi_ev_w, ext_ev_w};
		nmi_nxt = nmi_ev_w;
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			dir_r <= 4'h0;
			out_r <= 4'h0;
			sel_r <= 4'h0;
			pol_r <= 4'h0;
			enable_r <= 5'h00;
			status_r <= 5'h00;
			nmi_r <= 1'b0;
		end else begin
			dir_r <= dir_nxt;
			out_r <= out_nxt;
			sel_r <= sel_nxt;
			pol_r <= pol_nxt;
			enable_r <= enable_nxt;
			status_r <= status_nxt;
			nmi_r <= nmi_nxt;
		end
	end

	// A pin chosen as interrupt is input-only whatever its direction bit
	assign o_gpio_irq_pin = out_r;
	assign o_gpio_irq_pin_oe = dir_r & ~sel_r;
	assign o_irq = |(status_r & enable_r);
	assign o_nmi_pulse = nmi_r;

	// Read data, valid only in the cycle after the read strobe
	always_comb begin
		rdata_nxt = 16'h0000;
		if (i_rd) begin
			case (i_addr)
				rscl_pkg::ADDR_CONFIG: rdata_nxt = {7'h00, held_w, cfg_r};
				rscl_pkg::ADDR_GPIO_DIR: rdata_nxt = {12'h000, dir_r};
				rscl_pkg::ADDR_GPIO_OUT: rdata_nxt = {12'h000, out_r};
				rscl_pkg::ADDR_PIN_LEVEL: begin
					rdata_nxt = {11'h000, filt_r[rscl_pkg::PIN_NMI],
						filt_r[GL +: NG]};
				end
				rscl_pkg::ADDR_IRQ_SEL: rdata_nxt = {8'h00, sel_r, 4'h0};
				rscl_pkg::ADDR_IRQ_POL: rdata_nxt = {12'h000, pol_r};
				rscl_pkg::ADDR_IRQ_STATUS: rdata_nxt = {11'h000, status_r};
				rscl_pkg::ADDR_IRQ_ENABLE: rdata_nxt = {11'h000, enable_r};
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;

	// Checks on the captured settings and the interrupt paths
	property p_cfg_hold;
		@(posedge i_clock) disable iff (!i_rstn)
		held_w && $past(held_w) |-> $stable(cfg_r);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold)
		else $error("held straps changed");

	property p_big_endian;
		@(posedge i_clock) disable iff (!i_rstn)
		st_r == rscl_pkg::ST_CAPTURE && !filt_r[rscl_pkg::PIN_BYTE_ORDER]
		|=> o_big_endian [*3];
	endproperty
	a_big_endian: assert property (p_big_endian)
		else $error("strap 0 did not give big-endian");

	property p_wide;
		@(posedge i_clock) disable iff (!i_rstn)
		st_r == rscl_pkg::ST_CAPTURE && filt_r[rscl_pkg::PIN_HOST_WIDTH]
		|=> o_host_port_wide && o_host_upper_lanes_en;
	endproperty
	a_wide: assert property (p_wide)
		else $error("width strap 1 did not give 32 bits");

	property p_narrow;
		@(posedge i_clock) disable iff (!i_rstn)
		held_w && !o_host_port_wide |-> !o_host_upper_lanes_en;
	endproperty
	a_narrow: assert property (p_narrow)
		else $error("upper lanes enabled in 16-bit mode");

	property p_pci_sel;
		@(posedge i_clock) disable iff (!i_rstn)
		o_pci_enable != o_host_port_enable &&
		o_gpio_hi_enable == o_host_port_enable;
	endproperty
	a_pci_sel: assert property (p_pci_sel)
		else $error("peripheral selection inconsistent");

	property p_autoinit;
		@(posedge i_clock) disable iff (!i_rstn)
		st_r == rscl_pkg::ST_CAPTURE &&
		filt_r[rscl_pkg::PIN_AUTOINIT] == 1'b0 |=> !o_pci_autoinit;
	endproperty
	a_autoinit: assert property (p_autoinit)
		else $error("auto-init on with strap 0");

	property p_boot_rom;
		@(posedge i_clock) disable iff (!i_rstn)
		st_r == rscl_pkg::ST_CAPTURE &&
		filt_r[rscl_pkg::PIN_BOOT_LO +: 2] == rscl_pkg::BOOT_ROM
		|=> o_boot_rom && !o_boot_host && !o_boot_none;
	endproperty
	a_boot_rom: assert property (p_boot_rom)
		else $error("boot strap 11 not decoded as ROM");

	property p_div6;
		@(posedge i_clock) disable iff (!i_rstn)
		o_emclk_tick && eclk_w == rscl_pkg::ECLK_DIV6
		|=> !o_emclk_tick [*5] ##1 o_emclk_tick;
	endproperty
	a_div6: assert property (p_div6)
		else $error("core/6 tick spacing wrong");

	property p_nmi;
		@(posedge i_clock) disable iff (!i_rstn)
		held_w && filt_r[rscl_pkg::PIN_NMI] && !prev_r[rscl_pkg::PIN_NMI]
		|=> o_nmi_pulse && status_r[rscl_pkg::STAT_NMI];
	endproperty
	a_nmi: assert property (p_nmi)
		else $error("nmi rising edge missed");

	property p_gpio_reset;
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(i_rstn) |-> o_gpio_irq_pin_oe == 4'h0;
	endproperty
	a_gpio_reset: assert property (p_gpio_reset)
		else $error("gpio drivers on after reset");

	property p_irq_input;
		@(posedge i_clock) disable iff (!i_rstn)
		(sel_r & o_gpio_irq_pin_oe) == 4'h0;
	endproperty
	a_irq_input: assert property (p_irq_input)
		else $error("interrupt pin driven");

	property p_ext_edge;
		@(posedge i_clock) disable iff (!i_rstn)
		held_w && sel_r[0] && !pol_r[0] && rise_w[GL] |=> status_r[0];
	endproperty
	a_ext_edge: assert property (p_ext_edge)
		else $error("external interrupt edge missed");

	c_capture: cover property (@(posedge i_clock) disable iff (!i_rstn)
		$rose(held_w));
	c_nmi: cover property (@(posedge i_clock) disable iff (!i_rstn)
		o_nmi_pulse);
	c_ext_irq: cover property (@(posedge i_clock) disable iff (!i_rstn)
		o_irq && |status_r[3:0]);
	c_tick: cover property (@(posedge i_clock) disable iff (!i_rstn)
		o_emclk_tick);
endmodule

// ---- testbench/rscl_board.sv ----
`timescale 1ns/1ps
// Board resistors on the straps plus the interrupt sources on the pins
module rscl_board (
	// Strap pattern and external pin levels wanted by the bench
	input wire logic [7:0] i_cfg,
	input wire logic i_nmi_lvl,
	input wire logic [3:0] i_ext_lvl,
	// Device side of the shared pins
	input wire logic [3:0] i_dev_out,
	input wire logic [3:0] i_dev_oe,
	// Levels seen by the device
	output logic o_order,
	output logic o_width,
	output logic o_pci,
	output logic o_autoinit,
	output logic [1:0] o_boot,
	output logic [1:0] o_eclk,
	output logic o_nmi,
	output logic [3:0] o_pin
);
	// Every boot strap has a resistor fitted, none is left floating
	assign o_boot = i_cfg[5:4];
	assign {o_eclk, o_pci, o_width, o_order} = {i_cfg[7:6], i_cfg[2:0]};
	// Auto-init stays pulled low while PCI is deselected
	assign o_autoinit = i_cfg[3] & i_cfg[2];
	assign o_nmi = i_nmi_lvl;
	// Pin level: the device driver wins, else the board source
	assign o_pin = (i_dev_oe & i_dev_out) | (~i_dev_oe & i_ext_lvl);
endmodule

// ---- testbench/rscl_top_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin \
	num_checks++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module rscl_top_tb;
	// Bench-driven inputs
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] cfg = 8'hC1;
	logic nmi_lvl = 1'b0;
	logic [3:0] ext_lvl = 4'hF;
	// Board and device nets
	logic s_order, s_width, s_pci, s_ai, s_nmi;
	logic [1:0] s_boot, s_eclk;
	logic [3:0] s_pin, o_gpio_irq_pin, o_gpio_irq_pin_oe;
	logic [15:0] o_rdata;
	logic o_config_valid, o_big_endian, o_host_port_wide;
	logic o_host_upper_lanes_en, o_pci_enable, o_host_port_enable;
	logic o_gpio_hi_enable, o_pci_autoinit, o_boot_none, o_boot_host;
	logic o_boot_rom, o_boot_reserved, o_emclk_use_ext, o_emclk_reserved;
	logic o_emclk_tick, o_nmi_pulse, o_irq;
	int errors = 0;
	int num_checks = 0;

	// 40 MHz clock
	always #12.5 i_clock = ~i_clock;

	rscl_board i_board (.i_cfg(cfg), .i_nmi_lvl(nmi_lvl),
		.i_ext_lvl(ext_lvl), .i_dev_out(o_gpio_irq_pin),
		.i_dev_oe(o_gpio_irq_pin_oe), .o_order(s_order),
		.o_width(s_width), .o_pci(s_pci), .o_autoinit(s_ai),
		.o_boot(s_boot), .o_eclk(s_eclk), .o_nmi(s_nmi), .o_pin(s_pin));

	rscl_top i_dut (.i_clock(i_clock), .i_rstn(i_rstn),
		.i_byte_order_strap(s_order), .i_host_width_strap(s_width),
		.i_pci_select(s_pci), .i_eeprom_autoinit_strap(s_ai),
		.i_boot_strap(s_boot), .i_ext_mem_clock_select(s_eclk),
		.i_nmi(s_nmi), .i_gpio_irq_pin(s_pin),
		.o_gpio_irq_pin(o_gpio_irq_pin),
		.o_gpio_irq_pin_oe(o_gpio_irq_pin_oe),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_config_valid(o_config_valid),
		.o_big_endian(o_big_endian), .o_host_port_wide(o_host_port_wide),
		.o_host_upper_lanes_en(o_host_upper_lanes_en),
		.o_pci_enable(o_pci_enable),
		.o_host_port_enable(o_host_port_enable),
		.o_gpio_hi_enable(o_gpio_hi_enable),
		.o_pci_autoinit(o_pci_autoinit), .o_boot_none(o_boot_none),
		.o_boot_host(o_boot_host), .o_boot_rom(o_boot_rom),
		.o_boot_reserved(o_boot_reserved),
		.o_emclk_use_ext(o_emclk_use_ext),
		.o_emclk_reserved(o_emclk_reserved), .o_emclk_tick(o_emclk_tick),
		.o_nmi_pulse(o_nmi_pulse), .o_irq(o_irq));

	// One-cycle write; ends settled so comb outputs can be looked at
	task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 `CHK(o_rdata, e)
	endtask

	// Count nmi pulses and divider ticks over a span of cycles
	task automatic watch(input int n, output int np, output int nt);
		np = 0;
		nt = 0;
		repeat (n) begin
			@(posedge i_clock);
			#1;
			if (o_nmi_pulse === 1'b1) np++;
			if (o_emclk_tick === 1'b1) nt++;
		end
	endtask

	// Pin level change, held long enough to pass the filter
	task automatic set_ext(input logic [3:0] v);
		@(posedge i_clock);
		ext_lvl <= v;
		repeat (8) @(posedge i_clock);
	endtask

	// Reset with a strap pattern, check defaults, decode and holding
	task automatic t_capture(input logic [7:0] c, input int n);
		int np;
		int nt;
		logic [10:0] g;
		@(posedge i_clock);
		cfg <= c;
		i_rstn <= 1'b0;
		repeat (n) @(posedge i_clock);
		i_rstn <= 1'b1;
		@(posedge i_clock);
		#1 g = {o_config_valid, o_big_endian, o_host_port_wide, o_pci_enable,
			o_pci_autoinit, o_boot_rom, o_emclk_use_ext, o_gpio_irq_pin_oe};
		`CHK(g, 11'h030)
		repeat (6) @(posedge i_clock);
		#1 g = {o_config_valid, o_big_endian, o_host_port_wide,
			o_host_upper_lanes_en};
		`CHK(g, {1'b1, ~c[0], c[1], c[1]})
		g = {o_pci_enable, o_host_port_enable, o_gpio_hi_enable};
		`CHK(g, {c[2], ~c[2], ~c[2]})
		`CHK(o_pci_autoinit, c[3])
		g = {o_boot_none, o_boot_host, o_boot_reserved, o_boot_rom};
		`CHK(g, 4'h8 >> c[5:4])
		g = {o_emclk_use_ext, o_emclk_reserved};
		`CHK(g, {c[7:6] == 2'h0, c[7:6] == 2'h3})
		// Straps move after capture; the latched setting must not
		@(posedge i_clock);
		cfg <= ~c;
		watch(24, np, nt);
		`CHK(nt, (c[7:6] == 2'h1) ? 6 : (c[7:6] == 2'h2) ? 4 : 0)
		`CHK(o_big_endian, ~c[0])
		rd_chk(rscl_pkg::ADDR_CONFIG, {8'h01, c});
		$display("test capture %h done", c);
	endtask

	// Rising edge of nmi gives one pulse, falling edge none
	task automatic t_nmi();
		int np;
		int nt;
		@(posedge i_clock);
		nmi_lvl <= 1'b1;
		watch(10, np, nt);
		`CHK(np, 1)
		rd_chk(rscl_pkg::ADDR_IRQ_STATUS, 16'h0010);
		@(posedge i_clock);
		nmi_lvl <= 1'b0;
		watch(10, np, nt);
		`CHK(np, 0)
		reg_wr(rscl_pkg::ADDR_IRQ_CLEAR, 16'h001F);
		rd_chk(rscl_pkg::ADDR_IRQ_STATUS, 16'h0000);
		$display("test nmi done");
	endtask

	// Shared pins as driven GPIO, then as edge interrupts
	task automatic t_gpio();
		reg_wr(rscl_pkg::ADDR_GPIO_DIR, 16'h000F);
		reg_wr(rscl_pkg::ADDR_GPIO_OUT, 16'h000A);
		`CHK({o_gpio_irq_pin_oe, o_gpio_irq_pin}, 8'hFA)
		repeat (6) @(posedge i_clock);
		rd_chk(rscl_pkg::ADDR_PIN_LEVEL, 16'h000A);
		// Driver drops: pins 4 and 6 rise to the board level
		reg_wr(rscl_pkg::ADDR_IRQ_SEL, 16'h00F0);
		`CHK(o_gpio_irq_pin_oe, 4'h0)
		reg_wr(rscl_pkg::ADDR_IRQ_POL, 16'h0002);
		reg_wr(rscl_pkg::ADDR_IRQ_ENABLE, 16'h000F);
		repeat (4) @(posedge i_clock);
		rd_chk(rscl_pkg::ADDR_IRQ_STATUS, 16'h0005);
		reg_wr(rscl_pkg::ADDR_IRQ_CLEAR, 16'h001F);
		`CHK(o_irq, 1'b0)
		set_ext(4'hD);
		`CHK(o_irq, 1'b1)
		set_ext(4'hF);
		set_ext(4'h7);
		rd_chk(rscl_pkg::ADDR_IRQ_STATUS, 16'h0002);
		set_ext(4'hF);
		rd_chk(rscl_pkg::ADDR_IRQ_STATUS, 16'h000A);
		reg_wr(rscl_pkg::ADDR_IRQ_ENABLE, 16'h0000);
		`CHK(o_irq, 1'b0)
		reg_wr(rscl_pkg::ADDR_IRQ_ENABLE, 16'h0008);
		`CHK(o_irq, 1'b1)
		reg_wr(rscl_pkg::ADDR_IRQ_CLEAR, 16'h000A);
		`CHK(o_irq, 1'b0)
		rd_chk(rscl_pkg::ADDR_IRQ_CLEAR, 16'h0000);
		rd_chk(4'hF, 16'h0000);
		reg_wr(rscl_pkg::ADDR_CONFIG, 16'h0000);
		rd_chk(rscl_pkg::ADDR_CONFIG, 16'h013F);
		$display("test gpio done");
	endtask

	// Counts line, then the verdict
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Main sequence; straps obey the board wiring throughout
	initial begin
		t_capture(8'h42, 7);
		t_capture(8'h9D, 2);
		t_capture(8'hE6, 2);
		t_capture(8'h3F, 2);
		t_nmi();
		t_gpio();
		print_verdict();
	end

	// Watchdog: the run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_clock);
		errors++;
		print_verdict();
	end
endmodule
